// File: design/gpp_pkg.sv
// gpp_pkg: register offsets, reset values and widths for the eight-pin port.
// assumes a byte-wide cpu register port with byte offsets from the port base.
package gpp_pkg;

  // ==========================================================================
  // widths
  localparam int unsigned GPP_DATA_W = 8;
  localparam int unsigned GPP_ADDR_W = 4;

  // ==========================================================================
  // register byte offsets from the port base
  localparam logic [GPP_ADDR_W-1:0] GPP_OFS_FUNC_SEL = 4'h0;
  localparam logic [GPP_ADDR_W-1:0] GPP_OFS_DIR      = 4'h2;
  localparam logic [GPP_ADDR_W-1:0] GPP_OFS_IN_LEVEL = 4'h4;
  localparam logic [GPP_ADDR_W-1:0] GPP_OFS_OUT_VAL  = 4'h6;
  localparam logic [GPP_ADDR_W-1:0] GPP_OFS_PULLUP   = 4'h8;
  localparam logic [GPP_ADDR_W-1:0] GPP_OFS_SLEW     = 4'hA;
  localparam logic [GPP_ADDR_W-1:0] GPP_OFS_ALT_CHO  = 4'hC;

  // ==========================================================================
  // reset values and fixed read values
  localparam logic [GPP_DATA_W-1:0] GPP_RST_CTRL   = 8'h00;
  localparam logic [GPP_DATA_W-1:0] GPP_RD_UNMAPPED = 8'h00;

  // ==========================================================================
  // per-pin alternate routing: bit set means the alternative has a function
  localparam logic [GPP_DATA_W-1:0] GPP_ALT0_PRESENT = 8'hFF;
  localparam logic [GPP_DATA_W-1:0] GPP_ALT1_PRESENT = 8'hFF;

endpackage

// File: design/gpp_port.sv
// gpp_port: one eight-pin general-purpose port with peripheral muxing.
// assumes a synchronous byte register port, pins and peripherals on i_core_clk.
//
// Overview of operation
// - function-select 0: pin is gpio, buffer follows direction and output value
// - function-select 1: selected peripheral drives the pin value and enable
// - reset clears function-select, all pins start as gpio
// - direction 0 tri-states the output buffer, direction 1 drives the pin
// - reset clears all direction bits, pins become inputs
// - input register is read-only and returns live pin levels, outputs included
// - output-value writes update driven gpio pins; reads return the written value
// - reset leaves the output-value register untouched
// - pull-up acts only in gpio mode with buffer off; never in alternate mode
// - reset clears all pull-up enables
// - slew bit 1 fast, 0 slow, in both gpio and alternate modes
// - reset clears all slew bits, pins start slow
// - alternate-choice picks first or second function, only when function-select set
// - alternatives route through a fixed mapping; reserved entries connect nothing
// - output value 0 with direction set drives low; clear releases to pull-up
// - all registers are byte read/write except the read-only input register
`timescale 1ns/1ps
module gpp_port #(
  parameter int unsigned            N_PINS       = 8,
  parameter logic [N_PINS-1:0]      ALT0_PRESENT = gpp_pkg::GPP_ALT0_PRESENT[N_PINS-1:0],
  parameter logic [N_PINS-1:0]      ALT1_PRESENT = gpp_pkg::GPP_ALT1_PRESENT[N_PINS-1:0]
) (
  input  wire logic                              i_core_clk,
  input  wire logic                              i_rstn,
  input  wire logic [gpp_pkg::GPP_ADDR_W-1:0]    i_reg_addr,
  input  wire logic                              i_reg_wr,
  input  wire logic                              i_reg_rd,
  input  wire logic [gpp_pkg::GPP_DATA_W-1:0]    i_reg_wdata,
  output logic      [gpp_pkg::GPP_DATA_W-1:0]    o_reg_rdata,
  input  wire logic [N_PINS-1:0]                 i_pin,
  output logic      [N_PINS-1:0]                 o_pin,
  output logic      [N_PINS-1:0]                 o_pin_oe,
  output logic      [N_PINS-1:0]                 o_pullup_en,
  output logic      [N_PINS-1:0]                 o_slew_fast,
  input  wire logic [N_PINS-1:0]                 i_alt0_out,
  input  wire logic [N_PINS-1:0]                 i_alt0_oe,
  input  wire logic [N_PINS-1:0]                 i_alt1_out,
  input  wire logic [N_PINS-1:0]                 i_alt1_oe,
  output logic      [N_PINS-1:0]                 o_alt0_in,
  output logic      [N_PINS-1:0]                 o_alt1_in
);
  import gpp_pkg::*;

  if (N_PINS < 1 || N_PINS > GPP_DATA_W) begin : g_bad_width
    $error("gpp_port: N_PINS must be 1 to 8");
  end

  localparam int unsigned PAD = GPP_DATA_W - N_PINS;

  // ==========================================================================
  // control registers
  logic [N_PINS-1:0] func_sel_q, func_sel_d;
  logic [N_PINS-1:0] dir_q,      dir_d;
  logic [N_PINS-1:0] pullup_q,   pullup_d;
  logic [N_PINS-1:0] slew_q,     slew_d;
  logic [N_PINS-1:0] alt_cho_q,  alt_cho_d;
  logic [N_PINS-1:0] out_val_q,  out_val_d;
  logic [N_PINS-1:0] wdata;

  assign wdata = i_reg_wdata[N_PINS-1:0];

  always_comb begin
    func_sel_d = func_sel_q;
    dir_d      = dir_q;
    pullup_d   = pullup_q;
    slew_d     = slew_q;
    alt_cho_d  = alt_cho_q;
    out_val_d  = out_val_q;
    if (i_reg_wr) begin
      // input level offset has no storage, writes there are dropped
      unique case (i_reg_addr)
        GPP_OFS_FUNC_SEL: func_sel_d = wdata;
        GPP_OFS_DIR:      dir_d      = wdata;
        GPP_OFS_PULLUP:   pullup_d   = wdata;
        GPP_OFS_SLEW:     slew_d     = wdata;
        GPP_OFS_ALT_CHO:  alt_cho_d  = wdata;
        GPP_OFS_OUT_VAL:  out_val_d  = wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      func_sel_q <= GPP_RST_CTRL[N_PINS-1:0];
      dir_q      <= GPP_RST_CTRL[N_PINS-1:0];
      pullup_q   <= GPP_RST_CTRL[N_PINS-1:0];
      slew_q     <= GPP_RST_CTRL[N_PINS-1:0];
      alt_cho_q  <= GPP_RST_CTRL[N_PINS-1:0];
    end else begin
      func_sel_q <= func_sel_d;
      dir_q      <= dir_d;
      pullup_q   <= pullup_d;
      slew_q     <= slew_d;
      alt_cho_q  <= alt_cho_d;
    end
  end

  // output value keeps its contents through reset
  always_ff @(posedge i_core_clk) begin
    out_val_q <= out_val_d;
  end

  // ==========================================================================
  // read path
  logic [GPP_DATA_W-1:0] rdata_q, rdata_d;

  always_comb begin
    rdata_d = rdata_q;
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        GPP_OFS_FUNC_SEL: rdata_d = {{PAD{1'b0}}, func_sel_q};
        GPP_OFS_DIR:      rdata_d = {{PAD{1'b0}}, dir_q};
        GPP_OFS_IN_LEVEL: rdata_d = {{PAD{1'b0}}, i_pin};
        GPP_OFS_OUT_VAL:  rdata_d = {{PAD{1'b0}}, out_val_q};
        GPP_OFS_PULLUP:   rdata_d = {{PAD{1'b0}}, pullup_q};
        GPP_OFS_SLEW:     rdata_d = {{PAD{1'b0}}, slew_q};
        GPP_OFS_ALT_CHO:  rdata_d = {{PAD{1'b0}}, alt_cho_q};
        default:          rdata_d = GPP_RD_UNMAPPED;
      endcase
    end
  end

  // ==========================================================================
  // pin multiplexing
  logic [N_PINS-1:0] pin_d, oe_d, pu_d, slew_fast_d, a0_in_d, a1_in_d;
  logic [N_PINS-1:0] pin_q, oe_q, pu_q, slew_fast_q, a0_in_q, a1_in_q;

  always_comb begin
    for (int i = 0; i < N_PINS; i++) begin
      a0_in_d[i] = 1'b0;
      a1_in_d[i] = 1'b0;
      if (!func_sel_q[i]) begin
        pin_d[i] = out_val_q[i];
        oe_d[i]  = dir_q[i];
        pu_d[i]  = pullup_q[i] & ~dir_q[i];
      end else begin
        pu_d[i] = 1'b0;
        if (alt_cho_q[i]) begin
          pin_d[i]   = ALT1_PRESENT[i] & i_alt1_out[i];
          oe_d[i]    = ALT1_PRESENT[i] & i_alt1_oe[i];
          a1_in_d[i] = ALT1_PRESENT[i] & i_pin[i];
        end else begin
          pin_d[i]   = ALT0_PRESENT[i] & i_alt0_out[i];
          oe_d[i]    = ALT0_PRESENT[i] & i_alt0_oe[i];
          a0_in_d[i] = ALT0_PRESENT[i] & i_pin[i];
        end
      end
      slew_fast_d[i] = slew_q[i];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_q     <= GPP_RD_UNMAPPED;
      pin_q       <= GPP_RST_CTRL[N_PINS-1:0];
      oe_q        <= GPP_RST_CTRL[N_PINS-1:0];
      pu_q        <= GPP_RST_CTRL[N_PINS-1:0];
      slew_fast_q <= GPP_RST_CTRL[N_PINS-1:0];
      a0_in_q     <= GPP_RST_CTRL[N_PINS-1:0];
      a1_in_q     <= GPP_RST_CTRL[N_PINS-1:0];
    end else begin
      rdata_q     <= rdata_d;
      pin_q       <= pin_d;
      oe_q        <= oe_d;
      pu_q        <= pu_d;
      slew_fast_q <= slew_fast_d;
      a0_in_q     <= a0_in_d;
      a1_in_q     <= a1_in_d;
    end
  end

  assign o_reg_rdata = rdata_q;
  assign o_pin       = pin_q;
  assign o_pin_oe    = oe_q;
  assign o_pullup_en = pu_q;
  assign o_slew_fast = slew_fast_q;
  assign o_alt0_in   = a0_in_q;
  assign o_alt1_in   = a1_in_q;

  // ==========================================================================
  // checks
  chk_gpio_dir_oe: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (func_sel_q == '0) |=> (o_pin_oe == $past(dir_q)))
    else $error("gpio output enable does not follow direction");

  chk_gpio_out_val: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (func_sel_q == '0 && dir_q == '1) |=> (o_pin == $past(out_val_q)))
    else $error("gpio pin value does not follow output value");

  chk_alt_drive: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (func_sel_q[0] && !alt_cho_q[0] && ALT0_PRESENT[0]) |=>
      (o_pin_oe[0] == $past(i_alt0_oe[0]) && o_pin[0] == $past(i_alt0_out[0])))
    else $error("alternate function does not drive the pin");

  chk_alt_pullup_off: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    ((o_pullup_en & ($past(func_sel_q) | $past(dir_q))) == '0))
    else $error("pull-up active outside gpio input mode");

  chk_reset_clear: assert property (@(posedge i_core_clk)
    $rose(i_rstn) |-> (func_sel_q == '0 && dir_q == '0 && pullup_q == '0 && slew_q == '0))
    else $error("control registers not cleared by reset");

  chk_in_level_read: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (i_reg_rd && i_reg_addr == GPP_OFS_IN_LEVEL) |=>
      (o_reg_rdata[N_PINS-1:0] == $past(i_pin)))
    else $error("input level read does not return pin level");

  chk_out_readback: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (i_reg_wr && i_reg_addr == GPP_OFS_OUT_VAL) ##1
      (i_reg_rd && i_reg_addr == GPP_OFS_OUT_VAL && !i_reg_wr) |=>
      (o_reg_rdata[N_PINS-1:0] == $past(i_reg_wdata[N_PINS-1:0], 2)))
    else $error("output value read back differs from last write");

  chk_slew_follow: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (i_reg_wr && i_reg_addr == GPP_OFS_SLEW) |=> ##1
      (o_slew_fast == $past(i_reg_wdata[N_PINS-1:0], 2)))
    else $error("slew output does not follow written value");

  chk_open_drain: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (!func_sel_q[0] && !out_val_q[0] && dir_q[0]) |=> (o_pin_oe[0] && !o_pin[0]))
    else $error("open-drain low not driven");

  chk_in_level_ro: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (i_reg_wr && i_reg_addr == GPP_OFS_IN_LEVEL) |=>
      ($stable(func_sel_q) && $stable(dir_q) && $stable(out_val_q)))
    else $error("write to input level changed a register");

  chk_gpio_oe_bits: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (((o_pin_oe ^ $past(dir_q))
      & ~$past(func_sel_q)) == '0))
    else $error("gpio pin enable differs from its direction bit");

  chk_gpio_pin_bits: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (((o_pin ^ $past(out_val_q))
      & $past(~func_sel_q & dir_q)) == '0))
    else $error("gpio output pin differs from its output value bit");

  chk_alt0_bits: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    ((((o_pin_oe ^ $past(i_alt0_oe)) | (o_pin ^ $past(i_alt0_out)))
      & $past(func_sel_q & ~alt_cho_q) & ALT0_PRESENT) == '0))
    else $error("first alternative does not control its pins");

  chk_alt1_bits: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    ((((o_pin_oe ^ $past(i_alt1_oe)) | (o_pin ^ $past(i_alt1_out)))
      & $past(func_sel_q & alt_cho_q) & ALT1_PRESENT) == '0))
    else $error("second alternative does not control its pins");

  chk_reserved_quiet: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (((o_pin_oe | o_pin | o_alt0_in | o_alt1_in) & $past(func_sel_q)
      & $past((alt_cho_q & ~ALT1_PRESENT) | (~alt_cho_q & ~ALT0_PRESENT))) == '0))
    else $error("reserved alternative reaches its pin");

  chk_alt_in_route: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (o_alt0_in == $past(i_pin & func_sel_q & ~alt_cho_q & ALT0_PRESENT))
      && (o_alt1_in == $past(i_pin & func_sel_q & alt_cho_q & ALT1_PRESENT)))
    else $error("pin level not routed to the selected peripheral");

  chk_pullup_gpio: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    o_pullup_en ==
      $past(pullup_q & ~dir_q & ~func_sel_q))
    else $error("pull-up enable differs from gpio input setting");

  chk_slew_mirror: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    o_slew_fast ==
      $past(slew_q))
    else $error("slew output differs from slew register");

  chk_reset_outputs: assert property (@(posedge i_core_clk)
    $rose(i_rstn) |->
      (o_pin_oe == '0 && o_pullup_en == '0 && o_slew_fast == '0 && alt_cho_q == '0))
    else $error("pin controls not cleared by reset");

  chk_out_val_write: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (i_reg_wr && i_reg_addr == GPP_OFS_OUT_VAL) |=>
      (out_val_q == $past(i_reg_wdata[N_PINS-1:0])))
    else $error("output value write not stored");

  chk_dir_write: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (i_reg_wr && i_reg_addr == GPP_OFS_DIR) |=>
      (dir_q == $past(i_reg_wdata[N_PINS-1:0]) && $stable(func_sel_q) && $stable(pullup_q)))
    else $error("direction write not stored or spilled over");

  chk_func_readback: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (i_reg_rd && i_reg_addr == GPP_OFS_FUNC_SEL) |=>
      (o_reg_rdata == {{PAD{1'b0}}, $past(func_sel_q)}))
    else $error("function select read back differs");

  chk_rdata_hold: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    !i_reg_rd |=>
      $stable(o_reg_rdata))
    else $error("read data changed without a read");

endmodule

// File: testbench/gpp_pin_model.sv
// gpp_pin_model: pads and far-side drivers around the port.
// assumes pad controls from the port and an external driver set by the bench.
`timescale 1ns/1ps
module gpp_pin_model (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_out,
  input  wire logic [7:0] i_oe,
  input  wire logic [7:0] i_pu,
  input  wire logic [7:0] i_ext_en,
  input  wire logic [7:0] i_ext_val,
  output logic      [7:0] o_lvl
);
  logic [7:0] flt_q = 8'h5A;
  // undriven pins without pull-up wander every cycle
  always @(negedge i_clk) flt_q <= ~flt_q;
  // port driver first, then external driver, then pull-up
  assign o_lvl = i_oe & i_out | ~i_oe & i_ext_en & i_ext_val | ~i_oe & ~i_ext_en & (i_pu | flt_q);
endmodule

// File: testbench/testbench.sv
// testbench: random and corner checks of the eight-pin port.
// assumes gpp_pkg, gpp_port and gpp_pin_model are compiled first.
`timescale 1ns/1ps
module testbench;
  import gpp_pkg::*;
  localparam logic [3:0] OFS [7] = '{GPP_OFS_FUNC_SEL, GPP_OFS_DIR, GPP_OFS_IN_LEVEL, GPP_OFS_OUT_VAL,
                                     GPP_OFS_PULLUP, GPP_OFS_SLEW, GPP_OFS_ALT_CHO};
  // reserved routing: pin 3 has no first function, only pins 4 and 5 have a second
  localparam logic [7:0] ALT0_MAP = 8'hF7;
  localparam logic [7:0] ALT1_MAP = 8'h30;
  logic       clk = 0, rstn = 0, wr = 0, rd = 0;
  logic [3:0] addr = 0;
  logic [7:0] wdata = 0, a0o = 0, a0e = 0, a1o = 0, a1e = 0, ext_en = 0, ext_val = 0;
  wire  [7:0] rdata, lvl, o_pin, oe, pu, slew, ai0, ai1;
  int         n_fail = 0, num_checks = 0, seed = 34570;
  logic [7:0] rv [7];
  always #25 clk = ~clk;
  gpp_port #(.ALT0_PRESENT(ALT0_MAP), .ALT1_PRESENT(ALT1_MAP)) gpp_port_i (.i_core_clk(clk), .i_rstn(rstn),
    .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_pin(lvl), .o_pin(o_pin), .o_pin_oe(oe), .o_pullup_en(pu),
    .o_slew_fast(slew), .i_alt0_out(a0o), .i_alt0_oe(a0e), .i_alt1_out(a1o), .i_alt1_oe(a1e),
    .o_alt0_in(ai0), .o_alt1_in(ai1));
  gpp_pin_model gpp_pin_model_i (.i_clk(clk), .i_out(o_pin), .i_oe(oe), .i_pu(pu), .i_ext_en(ext_en),
    .i_ext_val(ext_val), .o_lvl(lvl));
  // ====
  // tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    wr = w;
    rd = ~w;
    addr = a;
    wdata = d;
    @(posedge clk);
    #1;
    wr = 0;
    rd = 0;
    // one idle edge between requests, so no strobe is set twice in a step
    @(posedge clk);
    #1;
  endtask
  task automatic chk_pins;
    logic [7:0] f, c, e_oe, e_pu, m;
    f = rv[0];
    c = rv[6];
    e_oe = ~f & rv[1] | f & ~c & a0e & ALT0_MAP | f & c & a1e & ALT1_MAP;
    e_pu = ~f & rv[4] & ~rv[1];
    m = e_oe | ext_en | e_pu;
    repeat (2) @(posedge clk);
    #1;
    chk(o_pin, ~f & rv[3] | f & ~c & a0o & ALT0_MAP | f & c & a1o & ALT1_MAP);
    chk(oe, e_oe);
    chk(pu, e_pu);
    chk(slew, rv[5]);
    chk(ai0 & m, f & ~c & ALT0_MAP & lvl & m);
    chk(ai1 & m, f & c & ALT1_MAP & lvl & m);
    acc(0, GPP_OFS_IN_LEVEL, 8'h00);
    chk(rdata & m, lvl & m);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ====
  // sequence
  initial begin
    repeat (5) @(posedge clk);
    #1;
    rstn = 1;
    @(posedge clk);
    #1;
    for (int i = 0; i < 7; i++) begin
      rv[i] = GPP_RST_CTRL;
      acc(0, OFS[i], 8'h00);
      if (i != 2 && i != 3)
        chk(rdata, GPP_RST_CTRL);
    end
    acc(1, GPP_OFS_OUT_VAL, 8'h00);
    chk_pins();
    $display("test reset values done");
    for (int k = 0; k < 40; k++) begin
      for (int i = 0; i < 7; i++) begin
        if (i != 2) begin
          rv[i] = 8'($random(seed));
          if (k == 0)
            rv[i] = (i == 1) ? 8'h0F : (i == 4) ? 8'hFF : 8'h00; // open-drain low and released
          if (i == 6)
            rv[i] = rv[i] & ALT1_MAP; // second choice only where a function exists
          acc(1, OFS[i], rv[i]);
        end
      end
      {a0o, a0e, a1o, a1e} = 32'($random(seed)); // peripherals enabled after function select
      {ext_en, ext_val} = 16'($random(seed));
      acc(1, GPP_OFS_IN_LEVEL, 8'($random(seed)));
      for (int i = 0; i < 7; i++) begin
        if (i != 2) begin
          acc(0, OFS[i], 8'h00);
          chk(rdata, rv[i]);
        end
      end
      acc(0, 4'hE, 8'h00);
      chk(rdata, GPP_RD_UNMAPPED);
      chk_pins();
    end
    $display("test random pins done");
    // back-to-back write then read of the output value
    wr = 1;
    addr = GPP_OFS_OUT_VAL;
    wdata = 8'hA5;
    @(posedge clk);
    #1;
    wr = 0;
    rd = 1;
    @(posedge clk);
    #1;
    rd = 0;
    chk(rdata, 8'hA5);
    @(posedge clk);
    #1;
    rstn = 0;
    @(posedge clk);
    #1;
    rstn = 1;
    @(posedge clk);
    #1;
    for (int i = 0; i < 7; i++) begin
      rv[i] = (i == 3) ? 8'hA5 : GPP_RST_CTRL;
      acc(0, OFS[i], 8'h00);
      if (i != 2)
        chk(rdata, rv[i]);
    end
    chk_pins();
    $display("test second reset done");
    stop_test();
  end
  initial begin
    #2000000;
    n_fail++;
    stop_test();
  end
endmodule
